// ### rtl/smart_selftest_threshold_autosave.sv
// Notes on behaviour
// - Low nibble of self-test byte: tenths still to run, 0 to 9 only.
// - High nibble: status code; 15 while running, 8 to 14 never reported.
// - Code 0 pass or never run, 1 host abort, 2 reset, 3 fatal.
// - Failed element codes: 4 unknown, 5 electrical, 6 servo/seek, 7 read.
// - Off-line capability bits 0, 3 and 4 are one.
// - Capability bit 2 says whether a new command aborts or suspends collection.
// - Health capability bits 0 and 1 are one, bits 2 to 15 zero.
// - Off-line collection time field holds seconds.
// - Polling-time fields hold least minutes before first completion poll.
// - Last byte of the 512-byte structure is a checksum of the others.
// - Threshold read: feature D1h, key C24Fh, count 01h, one 512-byte block.
// - Threshold read: busy while filling, then data request, busy off, interrupt.
// - Structure opens with revision 0005h; bytes 362 to 510 are zero.
// - Bytes 2 to 361 hold thirty 12-byte entries.
// - Entry byte 0 identifier, byte 1 threshold, rest zero; FEh marks unused.
// - Autosave feature D2h: count F1h enables, other non-zero leaves unchanged.
// - Count zero disables autosave; other saves still allowed.
// - With autosave on, mode transitions request an attribute save.
// - Autosave state kept non-volatile across power cycles.
// - Autosave command: busy, apply, busy off, interrupt.
`timescale 1ns/10ps

module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_r;
    logic [AW:0] rd_ptr_r;
    logic push;
    logic pop;

    assign out_valid = (wr_ptr_r != rd_ptr_r);
    assign in_ready = !((wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]) && (wr_ptr_r[AW] != rd_ptr_r[AW]));
    assign push = clk_en && in_valid && in_ready;
    assign pop = clk_en && out_valid && out_ready;
    assign out_data = mem[rd_ptr_r[AW-1:0]];

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr_r[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end
endmodule : byte_fifo

module smart_selftest_threshold_autosave
    import smart_pkg::*;
#(
    parameter int FIFO_DEPTH = 16,
    parameter logic [2:0] UNIT_ID = 3'h0,
    parameter logic ABORT_ON_CMD = 1'b0,
    parameter logic [15:0] OFFLINE_SECONDS = 16'h0000,
    parameter logic [7:0] POLL_SHORT_MIN = 8'h01,
    parameter logic [7:0] POLL_EXT_MIN = 8'h01
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    // Task file
    input wire logic cmd_valid,
    input wire logic [7:0] command_register,
    input wire logic [7:0] features_register,
    input wire logic [7:0] sector_count_register,
    input wire logic [15:0] track_key_registers,
    input wire logic [2:0] unit_select,
    input wire logic status_read,
    output logic busy_r,
    output logic drq_r,
    output logic intrq_r,
    output logic abort_r,
    output logic sc_done_r,
    // Data-in stream
    output logic data_valid_r,
    output logic [7:0] data_out_r,
    input wire logic data_ready,
    // Threshold table load
    input wire logic thr_wr_en,
    input wire logic [4:0] thr_wr_index,
    input wire logic [7:0] thr_wr_id,
    input wire logic [7:0] thr_wr_value,
    // Self-test results
    input wire logic selftest_update,
    input wire logic [3:0] selftest_code_in,
    input wire logic [3:0] selftest_remain_in,
    input wire logic selftest_reset_hit,
    output logic [7:0] selftest_status_r,
    // Capability fields
    output logic [7:0] offline_cap_r,
    output logic [15:0] smart_cap_r,
    output logic [15:0] offline_time_r,
    output logic [7:0] poll_short_r,
    output logic [7:0] poll_ext_r,
    // Autosave and non-volatile store
    input wire logic nv_autosave_pin,
    input wire logic mode_transition,
    output logic autosave_en_r,
    output logic nv_write_r,
    output logic attr_save_req_r
);
    cmd_state_t state_r;
    logic [7:0] ent_id [ENT_COUNT];
    logic [7:0] ent_thr [ENT_COUNT];
    logic gen_active_r;
    logic [8:0] idx_r;
    logic [3:0] ent_off_r;
    logic [4:0] ent_idx_r;
    logic [7:0] sum_r;
    logic [7:0] gen_byte;
    logic in_entry;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [7:0] fifo_out_data;
    logic push;
    logic take;
    logic [8:0] taken_r;
    logic accept;
    logic is_thr;
    logic is_autosave;
    logic nv_meta_r;
    logic nv_sync_r;
    logic nv_loaded_r;
    logic [7:0] host_sum_r;

    // Only idle takes a command; the host may not overlap them
    assign accept = clk_en && cmd_valid && (state_r == S_IDLE) && (unit_select == UNIT_ID);
    assign is_thr = (command_register == CMD_SMART) && (track_key_registers == TRACK_KEY)
        && (features_register == FEAT_READ_THR) && (sector_count_register == SC_ONE_BLOCK);
    assign is_autosave = (command_register == CMD_SMART) && (track_key_registers == TRACK_KEY)
        && (features_register == FEAT_AUTOSAVE);
    assign in_entry = (idx_r >= IDX_ENT_FIRST) && (idx_r <= IDX_ENT_LAST);
    assign push = clk_en && gen_active_r && fifo_in_ready;
    assign fifo_out_ready = !data_valid_r || data_ready;
    assign take = clk_en && data_valid_r && data_ready;

    always_comb begin
        gen_byte = BYTE_ZERO;
        if (idx_r == IDX_REV_LO) begin
            gen_byte = THR_REVISION[7:0];
        end else if (idx_r == IDX_REV_HI) begin
            gen_byte = THR_REVISION[15:8];
        end else if (in_entry && ent_off_r == ENT_OFF_ID) begin
            gen_byte = ent_id[ent_idx_r];
        end else if (in_entry && ent_off_r == ENT_OFF_THR) begin
            gen_byte = ent_thr[ent_idx_r];
        end else if (idx_r == IDX_CHECKSUM) begin
            gen_byte = 8'(BYTE_ZERO - sum_r);
        end
    end

    // Table defaults to unused entries until firmware loads it
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < ENT_COUNT; i++) begin
                ent_id[i] <= BYTE_ZERO;
                ent_thr[i] <= THR_UNUSED;
            end
        end else if (clk_en && thr_wr_en && thr_wr_index <= ENT_IDX_LAST) begin
            ent_id[thr_wr_index] <= thr_wr_id;
            ent_thr[thr_wr_index] <= thr_wr_value;
        end
    end

    // Structure generator feeding the buffer
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            gen_active_r <= 1'b0;
            idx_r <= '0;
            ent_off_r <= '0;
            ent_idx_r <= '0;
            sum_r <= '0;
        end else if (accept && is_thr) begin
            gen_active_r <= 1'b1;
            idx_r <= '0;
            ent_off_r <= '0;
            ent_idx_r <= '0;
            sum_r <= '0;
        end else if (push) begin
            sum_r <= sum_r + gen_byte;
            idx_r <= idx_r + 1'b1;
            if (idx_r == IDX_CHECKSUM) begin
                gen_active_r <= 1'b0;
            end
            if (in_entry) begin
                if (ent_off_r == ENT_OFF_LAST) begin
                    ent_off_r <= '0;
                    ent_idx_r <= ent_idx_r + 1'b1;
                end else begin
                    ent_off_r <= ent_off_r + 1'b1;
                end
            end
        end
    end

    byte_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rst(rst),
        .clk_en(clk_en),
        .in_valid(gen_active_r),
        .in_ready(fifo_in_ready),
        .in_data(gen_byte),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // Output stage keeps data ports on flip-flops
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            data_valid_r <= 1'b0;
            data_out_r <= '0;
        end else if (clk_en && fifo_out_ready) begin
            data_valid_r <= fifo_out_valid;
            // Only real bytes are loaded, so an empty slot never reaches the port
            if (fifo_out_valid) begin
                data_out_r <= fifo_out_data;
            end
        end
    end

    // Command sequencer
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r <= S_IDLE;
            busy_r <= 1'b0;
            drq_r <= 1'b0;
            abort_r <= 1'b0;
            sc_done_r <= 1'b0;
            taken_r <= '0;
        end else if (clk_en) begin
            case (state_r)
                S_IDLE: begin
                    if (accept && is_thr) begin
                        busy_r <= 1'b1;
                        abort_r <= 1'b0;
                        sc_done_r <= 1'b0;
                        taken_r <= '0;
                        state_r <= S_FILL;
                    end else if (accept && is_autosave) begin
                        busy_r <= 1'b1;
                        abort_r <= 1'b0;
                        state_r <= S_AUTOSAVE;
                    end else if (accept) begin
                        abort_r <= 1'b1;
                    end
                end
                S_FILL: begin
                    // Buffer holds only part of the block, so data request opens once it is full
                    if (!fifo_in_ready || !gen_active_r) begin
                        busy_r <= 1'b0;
                        drq_r <= 1'b1;
                        state_r <= S_XFER;
                    end
                end
                S_XFER: begin
                    if (take) begin
                        taken_r <= taken_r + 1'b1;
                        if (taken_r == IDX_CHECKSUM) begin
                            drq_r <= 1'b0;
                            sc_done_r <= 1'b1;
                            state_r <= S_IDLE;
                        end
                    end
                end
                S_AUTOSAVE: begin
                    busy_r <= 1'b0;
                    state_r <= S_IDLE;
                end
                default: begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end

    // Interrupt: a new raise wins over a status read in the same cycle
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            intrq_r <= 1'b0;
        end else if (clk_en) begin
            if ((state_r == S_FILL && (!fifo_in_ready || !gen_active_r))
                || state_r == S_AUTOSAVE || (accept && !is_thr && !is_autosave)) begin
                intrq_r <= 1'b1;
            end else if (status_read) begin
                intrq_r <= 1'b0;
            end
        end
    end

    // Non-volatile autosave setting, restored once after reset
    // Synchroniser has no reset: it keeps sampling during reset, so it is settled at release
    always_ff @(posedge ref_clk) begin
        if (clk_en) begin
            nv_meta_r <= nv_autosave_pin;
            nv_sync_r <= nv_meta_r;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            nv_loaded_r <= 1'b0;
            autosave_en_r <= 1'b0;
            nv_write_r <= 1'b0;
        end else if (clk_en) begin
            nv_write_r <= 1'b0;
            if (!nv_loaded_r) begin
                nv_loaded_r <= 1'b1;
                autosave_en_r <= nv_sync_r;
            end else if (state_r == S_AUTOSAVE) begin
                if (sector_count_register == SC_AUTOSAVE_ON) begin
                    autosave_en_r <= 1'b1;
                    nv_write_r <= 1'b1;
                end else if (sector_count_register == SC_AUTOSAVE_OFF) begin
                    autosave_en_r <= 1'b0;
                    nv_write_r <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            attr_save_req_r <= 1'b0;
        end else if (clk_en) begin
            attr_save_req_r <= mode_transition && autosave_en_r;
        end
    end

    // Self-test status byte; reserved codes fold into fatal
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            selftest_status_r <= {ST_PASS, REMAIN_DONE};
        end else if (clk_en) begin
            if (selftest_reset_hit && selftest_status_r[7:4] == ST_RUNNING) begin
                selftest_status_r <= {ST_RESET_INT, REMAIN_DONE};
            end else if (selftest_update) begin
                if (selftest_code_in == ST_RUNNING) begin
                    selftest_status_r <= {ST_RUNNING, (selftest_remain_in > REMAIN_MAX)
                        ? REMAIN_MAX : selftest_remain_in};
                end else if (selftest_code_in > ST_LAST_FAIL) begin
                    selftest_status_r <= {ST_FATAL, REMAIN_DONE};
                end else begin
                    selftest_status_r <= {selftest_code_in, REMAIN_DONE};
                end
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            offline_cap_r <= CAP_OFFLINE_NONE;
            smart_cap_r <= CAP_SMART_NONE;
            offline_time_r <= '0;
            poll_short_r <= '0;
            poll_ext_r <= '0;
        end else if (clk_en) begin
            offline_cap_r <= CAP_OFFLINE_NONE;
            offline_cap_r[CAP_IMMEDIATE] <= 1'b1;
            offline_cap_r[CAP_READ_SCAN] <= 1'b1;
            offline_cap_r[CAP_SELFTEST] <= 1'b1;
            offline_cap_r[CAP_ABORT_RESTART] <= ABORT_ON_CMD;
            smart_cap_r <= CAP_SMART_NONE;
            smart_cap_r[CAP_SAVE_PWR] <= 1'b1;
            smart_cap_r[CAP_AUTOSAVE] <= 1'b1;
            offline_time_r <= OFFLINE_SECONDS;
            poll_short_r <= POLL_SHORT_MIN;
            poll_ext_r <= POLL_EXT_MIN;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            host_sum_r <= '0;
        end else if (accept && is_thr) begin
            host_sum_r <= '0;
        end else if (take) begin
            host_sum_r <= host_sum_r + data_out_r;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    chk_remain_legal: assert property (selftest_status_r[3:0] <= REMAIN_MAX)
        else $error("remaining tenths above nine");
    chk_code_reserved: assert property (!(selftest_status_r[7:4] > ST_LAST_FAIL
        && selftest_status_r[7:4] != ST_RUNNING))
        else $error("reserved self-test code shown");
    chk_reset_code: assert property (clk_en && selftest_reset_hit
        && selftest_status_r[7:4] == ST_RUNNING |=> selftest_status_r[7:4] == ST_RESET_INT)
        else $error("reset during test not reported");
    chk_fail_element: assert property (clk_en && selftest_update && !selftest_reset_hit
        && selftest_code_in <= ST_LAST_FAIL |=> selftest_status_r == {$past(selftest_code_in),
        REMAIN_DONE})
        else $error("failed element code lost");
    chk_cap_bits: assert property (!$past(rst) && $past(clk_en) |-> offline_cap_r[CAP_IMMEDIATE]
        && offline_cap_r[CAP_READ_SCAN] && offline_cap_r[CAP_SELFTEST]
        && offline_cap_r[CAP_ABORT_RESTART] == ABORT_ON_CMD)
        else $error("off-line capability bits wrong");
    chk_smart_cap: assert property (!$past(rst) && $past(clk_en) |-> smart_cap_r == 16'h0003)
        else $error("health capability wrong");
    chk_rev_first: assert property (push && idx_r == IDX_REV_LO |-> gen_byte == 8'h05)
        else $error("revision byte wrong");
    chk_block_sum: assert property (take && taken_r == IDX_CHECKSUM
        |-> 8'(host_sum_r + data_out_r) == BYTE_ZERO)
        else $error("block does not sum to zero");
    chk_fill_busy: assert property (state_r == S_FILL |-> busy_r && !drq_r)
        else $error("data request before buffer filled");
    chk_drq_irq: assert property (clk_en && state_r == S_FILL && $rose(drq_r) == 1'b0
        ##1 $rose(drq_r) |-> !busy_r && intrq_r)
        else $error("data request without interrupt");
    chk_autosave_on: assert property (accept && is_autosave
        && sector_count_register == SC_AUTOSAVE_ON ##1 clk_en
        |=> autosave_en_r && intrq_r && !busy_r)
        else $error("autosave not enabled");
    chk_autosave_keep: assert property (accept && is_autosave && nv_loaded_r
        && sector_count_register != SC_AUTOSAVE_ON && sector_count_register != SC_AUTOSAVE_OFF
        ##1 clk_en |=> autosave_en_r == $past(autosave_en_r, 2))
        else $error("autosave changed by other count");
    chk_autosave_busy: assert property (accept && is_autosave |=> busy_r)
        else $error("autosave command without busy");

    cov_thr_done: cover property (take && taken_r == IDX_CHECKSUM);
    cov_autosave_off: cover property (nv_write_r && !autosave_en_r);
    cov_test_running: cover property (selftest_status_r[7:4] == ST_RUNNING);
    cov_save_req: cover property (attr_save_req_r);
endmodule : smart_selftest_threshold_autosave

// ### rtl/smart_pkg.sv
package smart_pkg;
    // Task-file command decode
    localparam logic [7:0] CMD_SMART = 8'hb0;
    localparam logic [7:0] FEAT_READ_THR = 8'hd1;
    localparam logic [7:0] FEAT_AUTOSAVE = 8'hd2;
    localparam logic [15:0] TRACK_KEY = 16'hc24f;
    localparam logic [7:0] SC_ONE_BLOCK = 8'h01;
    localparam logic [7:0] SC_AUTOSAVE_ON = 8'hf1;
    localparam logic [7:0] SC_AUTOSAVE_OFF = 8'h00;
    localparam logic [7:0] SC_DONE = 8'h00;
    // Threshold structure layout
    localparam logic [15:0] THR_REVISION = 16'h0005;
    localparam logic [8:0] IDX_REV_LO = 9'h000;
    localparam logic [8:0] IDX_REV_HI = 9'h001;
    localparam logic [8:0] IDX_ENT_FIRST = 9'h002;
    localparam logic [8:0] IDX_ENT_LAST = 9'h169;
    localparam logic [8:0] IDX_CHECKSUM = 9'h1ff;
    localparam logic [3:0] ENT_OFF_ID = 4'h0;
    localparam logic [3:0] ENT_OFF_THR = 4'h1;
    localparam logic [3:0] ENT_OFF_LAST = 4'hb;
    localparam int ENT_COUNT = 30;
    localparam logic [4:0] ENT_IDX_LAST = 5'h1d;
    localparam logic [7:0] THR_UNUSED = 8'hfe;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    // Self-test status byte
    localparam logic [3:0] ST_PASS = 4'h0;
    localparam logic [3:0] ST_RESET_INT = 4'h2;
    localparam logic [3:0] ST_FATAL = 4'h3;
    localparam logic [3:0] ST_LAST_FAIL = 4'h7;
    localparam logic [3:0] ST_RUNNING = 4'hf;
    localparam logic [3:0] REMAIN_MAX = 4'h9;
    localparam logic [3:0] REMAIN_DONE = 4'h0;
    // Capability bytes
    localparam int CAP_IMMEDIATE = 0;
    localparam int CAP_ABORT_RESTART = 2;
    localparam int CAP_READ_SCAN = 3;
    localparam int CAP_SELFTEST = 4;
    localparam int CAP_SAVE_PWR = 0;
    localparam int CAP_AUTOSAVE = 1;
    localparam logic [7:0] CAP_OFFLINE_NONE = 8'h00;
    localparam logic [15:0] CAP_SMART_NONE = 16'h0000;

    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_FILL = 2'b01,
        S_XFER = 2'b10,
        S_AUTOSAVE = 2'b11
    } cmd_state_t;
endpackage : smart_pkg

// ### verif/host_sink.sv
`timescale 1ns/10ps
module host_sink (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Data-in stream
    input wire logic sink_en,
    input wire logic data_valid_r,
    input wire logic [7:0] data_out_r,
    output logic data_ready
);
    logic [7:0] mem [0:511];
    int cnt = 0;
    int phase = 0;
    initial data_ready = 1'b0;
    // Stall one cycle in three so the buffer both fills and drains
    always @(negedge ref_clk) begin
        phase <= phase + 1;
        data_ready <= sink_en && (phase % 3 != 2);
    end
    // One block is taken, byte by byte, only on an accepted handshake
    always @(posedge ref_clk) begin
        if (!rst && data_valid_r && data_ready && cnt < 512) begin
            mem[cnt] <= data_out_r;
            cnt <= cnt + 1;
        end
    end
endmodule : host_sink

// ### verif/testbench.sv
`timescale 1ns/10ps
module testbench;
    import smart_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic cmd_valid = 1'b0, status_read = 1'b0, thr_wr_en = 1'b0, sink_en = 1'b0;
    logic selftest_update = 1'b0, hit = 1'b0, nv_pin = 1'b0, mode_transition = 1'b0;
    logic [7:0] feat = 8'h00, sc = 8'h00, wr_id = 8'h00, wr_val = 8'h00, expb, sum;
    logic [4:0] wr_idx = 5'h00;
    logic [3:0] st_code = 4'h0, st_rem = 4'h0;
    logic [2:0] unit = 3'h0;
    logic [15:0] key = TRACK_KEY;
    logic busy_r, drq_r, intrq_r, abort_r, sc_done_r, data_valid_r, data_ready;
    logic [7:0] data_out_r, selftest_status_r, offline_cap_r, poll_short_r, poll_ext_r;
    logic [15:0] smart_cap_r, offline_time_r;
    logic autosave_en_r, nv_write_r, attr_save_req_r;
    logic [7:0] tid [0:29];
    logic [7:0] tthr [0:29];
    int errors = 0;
    int samples_checked = 0;
    int n;
    int seen;

    always #20 ref_clk = ~ref_clk;

    smart_selftest_threshold_autosave #(.OFFLINE_SECONDS(16'h012c),
        .POLL_SHORT_MIN(8'h02), .POLL_EXT_MIN(8'h1e)) smart_selftest_threshold_autosave_inst (
        .ref_clk, .rst, .clk_en(1'b1), .cmd_valid, .command_register(CMD_SMART),
        .features_register(feat), .sector_count_register(sc), .track_key_registers(key),
        .unit_select(unit), .status_read, .busy_r, .drq_r, .intrq_r, .abort_r, .sc_done_r,
        .data_valid_r, .data_out_r, .data_ready, .thr_wr_en, .thr_wr_index(wr_idx),
        .thr_wr_id(wr_id), .thr_wr_value(wr_val), .selftest_update,
        .selftest_code_in(st_code), .selftest_remain_in(st_rem), .selftest_reset_hit(hit),
        .selftest_status_r, .offline_cap_r, .smart_cap_r, .offline_time_r, .poll_short_r,
        .poll_ext_r, .nv_autosave_pin(nv_pin), .mode_transition, .autosave_en_r,
        .nv_write_r, .attr_save_req_r);

    host_sink host_sink_inst (.ref_clk, .rst, .sink_en, .data_valid_r, .data_out_r,
        .data_ready);

    task report_and_stop;
        if (errors == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : report_and_stop

    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task tick(input int k);
        repeat (k) @(negedge ref_clk);
    endtask : tick

    task limit(input int lim);
        if (n >= lim) begin
            errors++;
            report_and_stop();
        end
    endtask : limit

    task issue(input logic [7:0] f, input logic [7:0] c);
        feat = f;
        sc = c;
        cmd_valid = 1'b1;
        tick(1);
        cmd_valid = 1'b0;
    endtask : issue

    task clear_irq;
        status_read = 1'b1;
        tick(1);
        status_read = 1'b0;
    endtask : clear_irq

    task load(input int i, input logic [7:0] id, input logic [7:0] v);
        wr_idx = i[4:0];
        wr_id = id;
        wr_val = v;
        thr_wr_en = 1'b1;
        tick(1);
        thr_wr_en = 1'b0;
        tick(1);
        if (i < 30) begin
            tid[i] = id;
            tthr[i] = v;
        end
    endtask : load

    // The count is held through the whole command, the device may sample it late
    task autosave(input logic [7:0] c, input logic en);
        issue(FEAT_AUTOSAVE, c);
        chk("busy", 1, busy_r);
        n = 0;
        while (busy_r !== 1'b0 && n < 32) begin
            tick(1);
            n++;
        end
        limit(32);
        if (c == SC_AUTOSAVE_ON) chk("nv_write", 1, nv_write_r);
        chk("intrq", 1, intrq_r);
        chk("autosave", en, autosave_en_r);
        clear_irq();
        mode_transition = 1'b1;
        tick(1);
        mode_transition = 1'b0;
        seen = 0;
        repeat (3) begin
            if (attr_save_req_r === 1'b1) seen++;
            tick(1);
        end
        chk("save_req", en, seen[15:0]);
    endtask : autosave

    task selftest(input logic [3:0] c, input logic [3:0] r, input logic h,
                  input logic [7:0] exp, input logic [7:0] mask);
        st_code = c;
        st_rem = r;
        selftest_update = ~h;
        hit = h;
        tick(1);
        selftest_update = 1'b0;
        hit = 1'b0;
        tick(1);
        chk("selftest", exp, selftest_status_r & mask);
    endtask : selftest

    initial begin
        for (int i = 0; i < 30; i++) begin
            tid[i] = 8'h00;
            tthr[i] = THR_UNUSED;
        end
        tick(16);
        rst = 1'b0;
        tick(4);
        chk("offline_cap", 8'h19, offline_cap_r);
        chk("smart_cap", 16'h0003, smart_cap_r);
        chk("offline_time", 16'h012c, offline_time_r);
        chk("poll", 16'h021e, {poll_short_r, poll_ext_r});
        chk("selftest", 0, selftest_status_r);
        load(0, 8'h01, 8'h00);
        load(7, 8'h0a, 8'h01);
        load(29, 8'hf0, 8'hfd);
        load(30, 8'h55, 8'h11);
        issue(FEAT_READ_THR, 8'h02);
        chk("abort", 1, abort_r);
        clear_irq();
        key = 16'h0000;
        issue(FEAT_READ_THR, SC_ONE_BLOCK);
        key = TRACK_KEY;
        chk("abort_key", 2, {abort_r, busy_r});
        clear_irq();
        unit = 3'h1;
        issue(FEAT_READ_THR, SC_ONE_BLOCK);
        unit = 3'h0;
        chk("busy", 0, busy_r);
        tick(1);
        issue(FEAT_READ_THR, SC_ONE_BLOCK);
        chk("busy", 1, busy_r);
        n = 0;
        while (drq_r !== 1'b1 && n < 64) begin
            tick(1);
            n++;
        end
        limit(64);
        chk("busy_intrq", 1, {busy_r, intrq_r});
        clear_irq();
        sink_en = 1'b1;
        n = 0;
        while (host_sink_inst.cnt < 512 && n < 4000) begin
            tick(1);
            n++;
        end
        limit(4000);
        tick(2);
        chk("drq_done", 1, {drq_r, sc_done_r});
        sum = 8'h00;
        for (int i = 0; i < 512; i++) begin
            expb = (i == 0) ? THR_REVISION[7:0] : (i == 1) ? THR_REVISION[15:8] : 8'h00;
            if (i >= 2 && i <= 361 && (i - 2) % 12 == 0) expb = tid[(i - 2) / 12];
            if (i >= 2 && i <= 361 && (i - 2) % 12 == 1) expb = tthr[(i - 2) / 12];
            if (i == 511) expb = 8'h00 - sum;
            sum = sum + expb;
            chk("thr_byte", expb, host_sink_inst.mem[i]);
        end
        autosave(SC_AUTOSAVE_ON, 1'b1);
        autosave(8'h05, 1'b1);
        autosave(SC_AUTOSAVE_OFF, 1'b0);
        for (int i = 0; i < 8; i++) selftest(i[3:0], 4'h0, 1'b0, {i[3:0], 4'h0}, 8'hff);
        selftest(ST_RUNNING, 4'hc, 1'b0, 8'hf9, 8'hff);
        selftest(4'h9, 4'h0, 1'b0, 8'h30, 8'hff);
        selftest(ST_RUNNING, 4'h5, 1'b0, 8'hf5, 8'hff);
        selftest(4'h0, 4'h0, 1'b1, 8'h20, 8'hf0);
        nv_pin = 1'b1;
        tick(4);
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        tick(4);
        chk("autosave", 1, autosave_en_r);
        report_and_stop();
    end
endmodule : testbench
